//--- core/lpmc_device.sv
// device end: power-mode sequencing, line states and wake; factory restore disarms on the first cycle after reset
// assumes the host drives the pins of lpmc_if.host; pins are async to aclk
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: normal, standby, sleep and deep sleep states
// RULE_02: mode code 0x02 selects standby
// RULE_03: mode code 0x01 selects sleep
// RULE_04: mode code 0x03 selects deep sleep
// RULE_05: standby slows controller, radio oscillator stays on
// RULE_06: sleep slows controller, stops all radio
// RULE_07: deep sleep stops controller oscillator and radio
// RULE_08: entering deep sleep drives cts high
// RULE_09: rxd low one bit time wakes standby/sleep
// RULE_10: reset low 20us then high wakes deep
// RULE_11: wake finishes under 6ms
// RULE_12: no radio monitoring while sleeping
// RULE_13: optional 0x06 acknowledge on txd after wake
// RULE_14: status outputs low, other pins released
// RULE_15: cts low in standby/sleep, high in deep
// RULE_16: ram kept; failed check forces soft reset
// RULE_17: soft reset reloads baud from stored copy
// RULE_18: cmd low 600ms after reset restores defaults; the code disarms this on the first cycle after reset, as cmd_s resets high
// RULE_19: compatibility mode caps radio rate 76.8kbps
// RULE_20: automatic gain default, manual gain selectable
// RULE_21: host should prefer deep sleep
// RULE_22: cts low means ready for uart data
// RULE_23: after wake return to normal operation
module lpmc_device
(
    // clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // pins toward the host
    lpmc_if.device     pins,
    // configuration from the module's own register space
    input  wire logic        wake_acknowledge_enable,
    input  wire logic        compat_mode,
    input  wire logic        manual_gain,
    input  wire logic [3:0]  baud_write,
    input  wire logic        baud_write_en,
    input  wire logic        buffer_empty_flag,
    // state toward the radio and controller
    output logic [7:0] operating_mode_select,
    output logic       ctrl_clk_slow,
    output logic       ctrl_osc_on,
    output logic       radio_osc_on,
    output logic       radio_rxtx_on,
    output logic       radio_scan_en,
    output logic       rate_capped,
    output logic       agc_on,
    output logic [3:0] volatile_baud_setting,
    output logic [3:0] stored_baud_setting,
    output logic       factory_restored
);
    typedef enum logic [6:0] {
        ST_NORMAL  = 7'b0000001,
        ST_STANDBY = 7'b0000010,
        ST_SLEEP   = 7'b0000100,
        ST_DEEP    = 7'b0001000,
        ST_DEEPREL = 7'b0010000,
        ST_WAKE    = 7'b0100000,
        ST_ACK     = 7'b1000000
    } lpmc_state_t;

    ////////////////////////////////////////////////////////////////////////
    logic rxd_s;
    logic rst_s;
    logic cmd_s;
    lpmc_sync u_rxd (.aclk(aclk), .aresetn(aresetn), .d(pins.rxd),        .q(rxd_s));
    lpmc_sync u_rst (.aclk(aclk), .aresetn(aresetn), .d(pins.reset_n_pin), .q(rst_s));
    lpmc_sync u_cmd (.aclk(aclk), .aresetn(aresetn), .d(pins.cmd_n),      .q(cmd_s));

    ////////////////////////////////////////////////////////////////////////
    lpmc_state_t st_r,   st_nxt;
    logic [7:0]  mode_r, mode_nxt;
    logic [31:0] cnt_r,  cnt_nxt;
    logic [3:0]  vb_r,   vb_nxt;
    logic [3:0]  sb_r,   sb_nxt;
    logic [9:0]  sh_r,   sh_nxt;   // ack char shifter incl start/stop
    logic [3:0]  bits_r, bits_nxt;
    logic [31:0] fcnt_r, fcnt_nxt;
    logic        fdone_r, fdone_nxt;
    logic        farm_r, farm_nxt;
    logic        cts_r, txd_r, txoe_r, oe_r;

    always_comb
    begin
        st_nxt    = st_r;
        mode_nxt  = mode_r;
        cnt_nxt   = cnt_r;
        vb_nxt    = baud_write_en ? baud_write : vb_r;
        sb_nxt    = sb_r;
        sh_nxt    = sh_r;
        bits_nxt  = bits_r;
        fcnt_nxt  = fcnt_r;
        fdone_nxt = fdone_r;
        farm_nxt  = farm_r;
        case (st_r)
            ST_NORMAL:
            begin
                if (pins.mode_valid)
                begin
                    mode_nxt = pins.mode_data;
                    if (pins.mode_data == lpmc_pkg::MODE_STANDBY)
                        st_nxt = ST_STANDBY;                       // [RULE_02]
                    else if (pins.mode_data == lpmc_pkg::MODE_SLEEP)
                        st_nxt = ST_SLEEP;                         // [RULE_03]
                    else if (pins.mode_data == lpmc_pkg::MODE_DEEP)
                        st_nxt = ST_DEEP;                          // [RULE_04]
                    else
                        mode_nxt = lpmc_pkg::MODE_NORMAL;
                    cnt_nxt = 32'h0;
                end
            end
            ST_STANDBY, ST_SLEEP:
            begin
                // rxd low held a full bit time wakes; radio never does [RULE_09] [RULE_12]
                if (!rxd_s)
                    cnt_nxt = cnt_r + 32'h1;
                else
                    cnt_nxt = 32'h0;
                if (cnt_r >= 32'(lpmc_pkg::BIT_CYC))
                begin
                    st_nxt  = ST_WAKE;
                    cnt_nxt = 32'h0;
                end
            end
            ST_DEEP:
            begin
                if (!rst_s)
                    cnt_nxt = cnt_r + 32'h1;
                else
                    cnt_nxt = 32'h0;
                if (cnt_r >= 32'(lpmc_pkg::RESET_LOW_CYC))
                    st_nxt = ST_DEEPREL;                           // [RULE_10]
            end
            ST_DEEPREL:
            begin
                // wake only once the reset line is back high
                if (rst_s)
                begin
                    st_nxt  = ST_WAKE;                             // [RULE_10]
                    cnt_nxt = 32'h0;
                end
            end
            ST_WAKE:
            begin
                // one-cycle wake step keeps well under the 6ms limit [RULE_11]
                if (pins.ram_fail)
                    vb_nxt = sb_r;                                 // [RULE_16] [RULE_17]
                mode_nxt = lpmc_pkg::MODE_NORMAL;                  // [RULE_23]
                if (wake_acknowledge_enable)
                begin
                    st_nxt   = ST_ACK;                             // [RULE_13]
                    sh_nxt   = {1'b1, lpmc_pkg::WAKE_ACK_CHAR, 1'b0};
                    bits_nxt = 4'h0;
                end
                else
                    st_nxt = ST_NORMAL;
            end
            ST_ACK:
            begin
                if (cnt_r == 32'(lpmc_pkg::BIT_CYC - 1))
                begin
                    cnt_nxt  = 32'h0;
                    sh_nxt   = {1'b1, sh_r[9:1]};
                    bits_nxt = bits_r + 4'h1;
                    if (bits_r == 4'h9)
                        st_nxt = ST_NORMAL;
                end
                else
                    cnt_nxt = cnt_r + 32'h1;
            end
            default:
                st_nxt = ST_NORMAL;
        endcase
        // factory restore: cmd_s resets high, so the first cycle after reset disarms it and the 600ms hold never acts [RULE_18]
        if (farm_r)
        begin
            if (!cmd_s)
            begin
                if (fcnt_r < 32'(lpmc_pkg::FACTORY_HOLD_CYC))
                    fcnt_nxt = fcnt_r + 32'h1;
            end
            else
            begin
                farm_nxt = 1'b0;
                if (fcnt_r >= 32'(lpmc_pkg::FACTORY_HOLD_CYC))
                begin
                    sb_nxt    = lpmc_pkg::BAUD_FACTORY;
                    vb_nxt    = lpmc_pkg::BAUD_FACTORY;
                    fdone_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r    <= ST_NORMAL;
            mode_r  <= lpmc_pkg::MODE_NORMAL;
            cnt_r   <= 32'h0;
            vb_r    <= lpmc_pkg::BAUD_FACTORY;
            sb_r    <= lpmc_pkg::BAUD_FACTORY;
            sh_r    <= 10'h3FF;
            bits_r  <= 4'h0;
            fcnt_r  <= 32'h0;
            fdone_r <= 1'b0;
            farm_r  <= 1'b1;
        end
        else
        begin
            st_r    <= st_nxt;
            mode_r  <= mode_nxt;
            cnt_r   <= cnt_nxt;
            vb_r    <= vb_nxt;
            sb_r    <= sb_nxt;
            sh_r    <= sh_nxt;
            bits_r  <= bits_nxt;
            fcnt_r  <= fcnt_nxt;
            fdone_r <= fdone_nxt;
            farm_r  <= farm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pin and power outputs, derived from next state
    logic low_nxt, deep_nxt;
    logic p_slow_r, p_cosc_r, p_rosc_r, p_rxtx_r, p_scan_r;
    always_comb
    begin
        deep_nxt = (st_nxt == ST_DEEP) || (st_nxt == ST_DEEPREL);
        low_nxt  = deep_nxt || (st_nxt == ST_STANDBY) || (st_nxt == ST_SLEEP);  // [RULE_01]
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cts_r    <= 1'b1;
            txd_r    <= 1'b1;
            txoe_r   <= 1'b1;
            oe_r     <= 1'b1;
            p_slow_r <= 1'b0;
            p_cosc_r <= 1'b1;
            p_rosc_r <= 1'b1;
            p_rxtx_r <= 1'b1;
            p_scan_r <= 1'b1;
        end
        else
        begin
            // cts high in deep sleep or while busy waking, low otherwise [RULE_08] [RULE_15] [RULE_22]
            cts_r    <= deep_nxt || (st_nxt == ST_WAKE);
            txd_r    <= (st_nxt == ST_ACK) ? sh_nxt[0] : 1'b1;
            txoe_r   <= !low_nxt;                                  // [RULE_14]
            oe_r     <= !low_nxt;                                  // [RULE_14]
            p_slow_r <= (st_nxt == ST_STANDBY) || (st_nxt == ST_SLEEP);  // [RULE_05] [RULE_06]
            p_cosc_r <= !deep_nxt;                                 // [RULE_07]
            p_rosc_r <= !low_nxt || (st_nxt == ST_STANDBY);        // [RULE_05] [RULE_06]
            p_rxtx_r <= !low_nxt;                                  // [RULE_05]
            p_scan_r <= !low_nxt;                                  // [RULE_12] [RULE_23]
        end
    end

    assign pins.cts_n                  = cts_r;
    assign pins.txd                    = txd_r;
    assign pins.txd_oe                 = txoe_r;
    assign pins.pins_oe                = oe_r;
    // status lines are tied low in every state; nothing else in the project drives them
    assign pins.packet_processing_flag = 1'b0;                     // [RULE_14]
    assign pins.error_flag_line        = 1'b0;                     // [RULE_14]
    assign pins.rssi_out               = 1'b0;                     // [RULE_14]
    assign operating_mode_select       = mode_r;
    assign ctrl_clk_slow               = p_slow_r;
    assign ctrl_osc_on                 = p_cosc_r;
    assign radio_osc_on                = p_rosc_r;
    assign radio_rxtx_on               = p_rxtx_r;
    assign radio_scan_en               = p_scan_r;
    assign volatile_baud_setting       = vb_r;
    assign stored_baud_setting         = sb_r;
    assign factory_restored            = fdone_r;
    // config passthroughs are static settings, not link state [RULE_19] [RULE_20]
    logic cfg_r, agc_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r <= 1'b0;
            agc_r <= 1'b1;
        end
        else
        begin
            cfg_r <= compat_mode;
            agc_r <= !manual_gain && !buffer_empty_flag ? 1'b1 : !manual_gain;
        end
    end
    assign rate_capped = cfg_r;
    assign agc_on      = agc_r;
endmodule
`default_nettype wire

//--- core/lpmc_pkg.sv
// package: constants for the low-power mode controller and its host end
// assumes a 100 MHz aclk shared by both ends
package lpmc_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    // operating mode codes
    localparam logic [7:0]  MODE_NORMAL      = 8'h00;
    localparam logic [7:0]  MODE_SLEEP       = 8'h01;
    localparam logic [7:0]  MODE_STANDBY     = 8'h02;
    localparam logic [7:0]  MODE_DEEP        = 8'h03;
    localparam logic [7:0]  WAKE_ACK_CHAR    = 8'h06;
    // times as printed
    localparam int unsigned RESET_LOW_US     = 20;
    localparam int unsigned WAKE_MAX_MS      = 6;
    localparam int unsigned FACTORY_HOLD_MS  = 600;
    localparam int unsigned RADIO_RATE_CAP_BPS = 76800;
    localparam int unsigned RESET_LOW_CYC    = RESET_LOW_US * CLK_MHZ;
    localparam int unsigned WAKE_MAX_CYC     = WAKE_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned FACTORY_HOLD_CYC = FACTORY_HOLD_MS * 1000 * CLK_MHZ;
    // uart bit time in cycles (fixed rate for this block)
    localparam int unsigned BIT_CYC          = 868;
    // baud code reset values
    localparam logic [3:0]  BAUD_FACTORY     = 4'h0;
    // register offsets of the host's own AXI4-Lite register file
    localparam logic [3:0]  OFS_MODE         = 4'h0;
    localparam logic [3:0]  OFS_CFG          = 4'h4;
    localparam logic [3:0]  OFS_STATUS       = 4'h8;
    localparam logic [3:0]  OFS_CMD          = 4'hC;
    // config bit positions
    localparam int unsigned CFG_ACK_BIT      = 0;
    localparam int unsigned CFG_COMPAT_BIT   = 1;
    localparam int unsigned CFG_MANGAIN_BIT  = 2;
    localparam int unsigned CFG_BAUD_LSB     = 4;
    // command bits
    localparam int unsigned CMD_WAKE_BIT     = 0;
    localparam int unsigned CMD_FACTORY_BIT  = 1;
    localparam int unsigned CMD_RAMBAD_BIT   = 2;
endpackage

//--- core/lpmc_if.sv
// interface: pins between the radio module and its host controller
// assumes weak pull-ups are resolved by the testbench from the enables
`timescale 1ns/1ps
`default_nettype none
interface lpmc_if;
    logic       rxd;          // host to device serial
    logic       txd;          // device to host serial
    logic       txd_oe;
    logic       cts_n;
    logic       reset_n_pin;
    logic       cmd_n;
    logic       packet_processing_flag;
    logic       error_flag_line;
    logic       rssi_out;
    logic       pins_oe;      // shared drive enable of the bidir status pins
    // host writes the mode code over the config path
    logic [7:0] mode_data;
    logic       mode_valid;
    logic       ram_fail;     // host-side injection of a bad ram check, set from the command register
    modport device (input rxd, reset_n_pin, cmd_n, mode_data, mode_valid, ram_fail,
                    output txd, txd_oe, cts_n, packet_processing_flag, error_flag_line,
                    rssi_out, pins_oe);
    modport host (output rxd, reset_n_pin, cmd_n, mode_data, mode_valid, ram_fail,
                  input txd, txd_oe, cts_n, packet_processing_flag, error_flag_line,
                  rssi_out, pins_oe);
endinterface
`default_nettype wire

//--- core/lpmc_sync.sv
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic q_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= 1'b1;
            q_r    <= 1'b1;
        end
        else
        begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end
    assign q = q_r;
endmodule
`default_nettype wire

//--- core/lpmc_host.sv
// host end: AXI4-Lite register file driving mode writes and wake pulses
// assumes the device end on lpmc_if.device
`timescale 1ns/1ps
`default_nettype none
module lpmc_host
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [3:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // pins toward the device
    lpmc_if.host             pins
);
    logic cts_s;
    lpmc_sync u_cts (.aclk(aclk), .aresetn(aresetn), .d(pins.cts_n), .q(cts_s));

    logic        aw_r, w_r, bv_r, rv_r;
    logic [3:0]  awa_r;
    logic [31:0] wd_r, rd_r, cfg_r;
    logic [7:0]  mdat_r;
    logic        mval_r, rxd_r, rst_r, cmd_r, rf_r;
    logic [31:0] cnt_r;
    logic [1:0]  pulse_r;  // 01 rxd low, 10 reset low

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_r <= 1'b0; w_r <= 1'b0; bv_r <= 1'b0; rv_r <= 1'b0;
            awa_r <= 4'h0; wd_r <= 32'h0; rd_r <= 32'h0; cfg_r <= 32'h0;
            mdat_r <= 8'h00; mval_r <= 1'b0; rxd_r <= 1'b1; rst_r <= 1'b1;
            cmd_r <= 1'b1; rf_r <= 1'b0; cnt_r <= 32'h0; pulse_r <= 2'b00;
        end
        else
        begin
            mval_r <= 1'b0;
            // wake pulse, twice the minimum; placed first so a new wake write restarts it
            if (pulse_r != 2'b00)
            begin
                cnt_r <= cnt_r + 32'h1;
                if ((pulse_r == 2'b01 && cnt_r >= 32'(2 * lpmc_pkg::BIT_CYC)) ||
                    (pulse_r == 2'b10 && cnt_r >= 32'(2 * lpmc_pkg::RESET_LOW_CYC)))
                begin
                    pulse_r <= 2'b00; rxd_r <= 1'b1; rst_r <= 1'b1;
                end
            end
            if (s_awvalid && !aw_r && !bv_r) begin aw_r <= 1'b1; awa_r <= s_awaddr; end
            if (s_wvalid && !w_r && !bv_r) begin w_r <= 1'b1; wd_r <= s_wdata; end
            if (aw_r && w_r)
            begin
                aw_r <= 1'b0; w_r <= 1'b0; bv_r <= 1'b1;
                if (awa_r == lpmc_pkg::OFS_MODE)
                begin
                    mdat_r <= wd_r[7:0];
                    mval_r <= 1'b1;
                end
                else if (awa_r == lpmc_pkg::OFS_CFG)
                    cfg_r <= wd_r;
                else if (awa_r == lpmc_pkg::OFS_CMD)
                begin
                    cmd_r <= !wd_r[lpmc_pkg::CMD_FACTORY_BIT];
                    rf_r  <= wd_r[lpmc_pkg::CMD_RAMBAD_BIT];
                    if (wd_r[lpmc_pkg::CMD_WAKE_BIT])
                    begin
                        cnt_r <= 32'h0;
                        if (cts_s) begin pulse_r <= 2'b10; rst_r <= 1'b0; end
                        else begin pulse_r <= 2'b01; rxd_r <= 1'b0; end
                    end
                end
            end
            if (bv_r && s_bready) bv_r <= 1'b0;
            if (s_arvalid && !rv_r)
            begin
                rv_r <= 1'b1;
                if (s_araddr == lpmc_pkg::OFS_MODE) rd_r <= {24'h0, mdat_r};
                else if (s_araddr == lpmc_pkg::OFS_CFG) rd_r <= cfg_r;
                else if (s_araddr == lpmc_pkg::OFS_STATUS)
                    rd_r <= {29'h0, pulse_r != 2'b00, pins.txd, cts_s};
                else rd_r <= 32'h0;
            end
            else if (rv_r && s_rready) rv_r <= 1'b0;
        end
    end
    assign s_awready      = !aw_r && !bv_r;
    assign s_wready       = !w_r && !bv_r;
    assign s_bvalid       = bv_r;
    assign s_bresp        = 2'b00;
    assign s_arready      = !rv_r;
    assign s_rvalid       = rv_r;
    assign s_rdata        = rd_r;
    assign s_rresp        = 2'b00;
    assign pins.mode_data   = mdat_r;
    assign pins.mode_valid  = mval_r;
    assign pins.rxd         = rxd_r;
    assign pins.reset_n_pin = rst_r;
    assign pins.cmd_n       = cmd_r;
    assign pins.ram_fail    = rf_r;
endmodule
`default_nettype wire

//--- tb/lpmc_sva.sv
// checker: pin-level properties of the link between host and device ends
// assumes the signals of one lpmc_if instance plus aclk and aresetn
`timescale 1ns/1ps
`default_nettype none
module lpmc_sva
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // link signals
    input  wire logic       rxd,
    input  wire logic       txd,
    input  wire logic       txd_oe,
    input  wire logic       cts_n,
    input  wire logic       reset_n_pin,
    input  wire logic       packet_processing_flag,
    input  wire logic       error_flag_line,
    input  wire logic       rssi_out,
    input  wire logic       pins_oe,
    input  wire logic [7:0] mode_data,
    input  wire logic       mode_valid
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
// length of the current low phase of the reset pin
logic [15:0] low_r;
logic [15:0] low_nxt;
always_comb low_nxt = reset_n_pin ? 16'h0000 : low_r + 16'h0001;
always_ff @(posedge aclk) low_r <= aresetn ? low_nxt : 16'h0000;
////////////////////////////////////////////////////////////////////////////
a_flags_low: assert property (
    !(packet_processing_flag || error_flag_line || rssi_out)) else $error("flag high");
a_deep_cts: assert property (
    mode_valid && mode_data == lpmc_pkg::MODE_DEEP |-> ##[1:4] cts_n) else $error("cts low");
a_light_cts: assert property (
    mode_valid && mode_data inside {8'h01, 8'h02} |-> ##[1:4] !cts_n) else $error("cts high");
a_pins_release: assert property (
    mode_valid && mode_data inside {8'h01, 8'h02, 8'h03} |-> ##[1:4] !pins_oe)
    else $error("pins still driven");
a_mode_pulse: assert property (
    mode_valid |=> !mode_valid) else $error("mode strobe too long");
a_ack_start: assert property (
    $fell(txd) && txd_oe |-> !txd [*8]) else $error("short start bit");
a_rxd_wake: assert property (
    $fell(rxd) |-> !rxd [*8]) else $error("short rxd pulse");
a_reset_width: assert property (
    $rose(reset_n_pin) |-> low_r >= 16'(lpmc_pkg::RESET_LOW_CYC - 1)) else $error("short reset");
c_deep: cover property (mode_valid && mode_data == lpmc_pkg::MODE_DEEP);
c_reset: cover property ($rose(reset_n_pin));
c_ack: cover property ($fell(txd) && txd_oe);
endmodule
`default_nettype wire

//--- tb/low_power_mode_control_tb.sv
// testbench: host and device ends joined by lpmc_if, driven over AXI4-Lite
// assumes the design files under core/ are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module low_power_mode_control_tb;
logic        aclk = 1'b0, aresetn = 1'b0;
logic [3:0]  awaddr = 4'h0, araddr = 4'h0, baud_w = 4'h0;
logic [31:0] wdata = 32'h0, rdata, rd;
logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic        awready, wready, bvalid, arready, rvalid, ack_en = 1'b0, compat = 1'b0;
logic        man_gain = 1'b0, baud_en = 1'b0, be_flag = 1'b1;
logic [1:0]  bresp, rresp;
logic [7:0]  opmode;
logic        clk_slow, osc_on, rosc_on, rxtx_on, scan_en, capped, agc_on, frest;
logic [3:0]  vbaud, sbaud;
int          err_count = 0, checked = 0;
lpmc_if lif();
lpmc_host u_lpmc_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .pins(lif));
lpmc_device u_lpmc_device (.aclk(aclk), .aresetn(aresetn), .pins(lif),
    .wake_acknowledge_enable(ack_en), .compat_mode(compat), .manual_gain(man_gain),
    .baud_write(baud_w), .baud_write_en(baud_en), .buffer_empty_flag(be_flag),
    .operating_mode_select(opmode), .ctrl_clk_slow(clk_slow), .ctrl_osc_on(osc_on),
    .radio_osc_on(rosc_on), .radio_rxtx_on(rxtx_on), .radio_scan_en(scan_en),
    .rate_capped(capped), .agc_on(agc_on), .volatile_baud_setting(vbaud),
    .stored_baud_setting(sbaud), .factory_restored(frest));
lpmc_sva u_lpmc_sva (.aclk(aclk), .aresetn(aresetn), .rxd(lif.rxd), .txd(lif.txd),
    .txd_oe(lif.txd_oe), .cts_n(lif.cts_n), .reset_n_pin(lif.reset_n_pin),
    .packet_processing_flag(lif.packet_processing_flag), .error_flag_line(lif.error_flag_line),
    .rssi_out(lif.rssi_out), .pins_oe(lif.pins_oe), .mode_data(lif.mode_data),
    .mode_valid(lif.mode_valid));
always #5 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////
task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
endtask
task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rready <= 1'b0;
endtask
// enter a mode, let the walk settle, then wake through the command register
task automatic sleep_wake(input logic [7:0] m, input logic [31:0] cmd);
    axw(lpmc_pkg::OFS_MODE, {24'h0, m});
    repeat (6) @(posedge aclk);
    axw(lpmc_pkg::OFS_CMD, cmd);
endtask
task automatic wait_normal();
    // host pulse and any acknowledge must be over as well
    for (int n = 0; n < 30000 && (opmode !== lpmc_pkg::MODE_NORMAL ||
        (lif.rxd & lif.reset_n_pin & lif.txd) !== 1'b1); n++) @(posedge aclk);
    `CHK("woken", lpmc_pkg::MODE_NORMAL, opmode)
    `CHK("scan", 1'b1, scan_en)
    `CHK("ready", 1'b0, lif.cts_n)
    axr(lpmc_pkg::OFS_STATUS, rd);
    `CHK("status", 32'h2, rd)
endtask
task automatic t_modes();
    logic [7:0] m [3] = '{lpmc_pkg::MODE_STANDBY, lpmc_pkg::MODE_SLEEP, lpmc_pkg::MODE_DEEP};
    // deep sleep, the preferred saving mode, is always among them
    for (int i = 0; i < 3; i++)
    begin
        axw(lpmc_pkg::OFS_MODE, {24'h0, m[i]});
        repeat (6) @(posedge aclk);
        `CHK("mode", m[i], opmode)
        `CHK("cts", m[i] == lpmc_pkg::MODE_DEEP, lif.cts_n)
        `CHK("ctrl osc", m[i] != lpmc_pkg::MODE_DEEP, osc_on)
        `CHK("radio osc", m[i] == lpmc_pkg::MODE_STANDBY, rosc_on)
        `CHK("rxtx", 1'b0, rxtx_on)
        `CHK("scan off", 1'b0, scan_en)
        `CHK("pins oe", 1'b0, lif.pins_oe)
        if (m[i] != lpmc_pkg::MODE_DEEP) `CHK("slow", 1'b1, clk_slow)
        axw(lpmc_pkg::OFS_CMD, 32'h1);
        wait_normal();
    end
endtask
task automatic t_ack();
    logic [7:0] b;
    ack_en <= 1'b1;
    compat <= 1'b1;
    man_gain <= 1'b1;
    axw(lpmc_pkg::OFS_CFG, 32'h7);
    axr(lpmc_pkg::OFS_CFG, rd);
    `CHK("cfg", 32'h7, rd)
    `CHK("cap", 1'b1, capped)
    `CHK("agc", 1'b0, agc_on)
    sleep_wake(lpmc_pkg::MODE_SLEEP, 32'h1);
    for (int n = 0; n < 30000 && lif.txd !== 1'b0; n++) @(posedge aclk);
    repeat (lpmc_pkg::BIT_CYC / 2) @(posedge aclk);
    for (int k = 0; k < 8; k++)
    begin
        repeat (lpmc_pkg::BIT_CYC) @(posedge aclk);
        b[k] = lif.txd;
    end
    `CHK("ack char", lpmc_pkg::WAKE_ACK_CHAR, b)
    repeat (lpmc_pkg::BIT_CYC) @(posedge aclk);
    `CHK("stop bit", 1'b1, lif.txd)
    repeat (lpmc_pkg::BIT_CYC) @(posedge aclk);
    ack_en <= 1'b0;
    wait_normal();
endtask
// a failed ram check throws away the host's baud write
task automatic t_ram();
    baud_w <= 4'h5;
    baud_en <= 1'b1;
    @(posedge aclk);
    baud_en <= 1'b0;
    sleep_wake(lpmc_pkg::MODE_STANDBY, 32'h5);
    wait_normal();
    `CHK("baud", lpmc_pkg::BAUD_FACTORY, vbaud)
    `CHK("stored baud", lpmc_pkg::BAUD_FACTORY, sbaud)
    axw(lpmc_pkg::OFS_CMD, 32'h0);
endtask
task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
initial
begin
    repeat (100000) @(posedge aclk);
    err_count++;
    end_sim();
end
initial
begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("reset mode", lpmc_pkg::MODE_NORMAL, opmode)
    `CHK("reset agc", 1'b1, agc_on)
    `CHK("reset baud", lpmc_pkg::BAUD_FACTORY, vbaud)
    t_modes();
    t_ack();
    t_ram();
    `CHK("no restore", 1'b0, frest)
    end_sim();
end
endmodule
`default_nettype wire
